// file: core/dot_pkg.sv
// Package: register map, field layout and message codes for trace block
package dot_pkg;
  localparam logic [31:0] OFS_CHAN_CTRL = 32'h0000_0000;
  localparam logic [31:0] OFS_START_0 = 32'h0000_0004;
  localparam logic [31:0] OFS_END_0 = 32'h0000_0008;
  localparam logic [31:0] OFS_START_1 = 32'h0000_000C;
  localparam logic [31:0] OFS_END_1 = 32'h0000_0010;
  localparam logic [31:0] OFS_PROCESS_ID = 32'h0000_0014;
  localparam logic [31:0] OFS_MODE = 32'h0000_0018;
  localparam logic [31:0] OFS_STATUS = 32'h0000_001C;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK = 32'hF00F_FFFF;
  localparam int SEL0_HI = 31;
  localparam int SEL1_HI = 29;
  localparam int SID1_LO = 12;
  localparam int SID1_EN = 11;
  localparam int SID0_LO = 3;
  localparam int SID0_EN = 2;
  localparam int WP1_BIT = 1;
  localparam int WP0_BIT = 0;
  localparam logic [5:0] TC_OWNERSHIP = 6'h02;
  localparam logic [5:0] TC_READ_REL = 6'h06;
  localparam logic [5:0] TC_WRITE_REL = 6'h05;
  localparam logic [5:0] TC_READ_SYNC = 6'h0E;
  localparam logic [5:0] TC_WRITE_SYNC = 6'h0D;
  localparam logic [5:0] TC_ERROR = 6'h08;
  localparam logic [5:0] TC_WATCHPOINT = 6'h0F;
  localparam logic [4:0] ERR_DATA_OVR = 5'h02;
  localparam logic [4:0] ERR_OWN_OVR = 5'h07;
  localparam logic [7:0] PERIOD_LIMIT = 8'hFF;
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [1:0] HT_NONSEQ = 2'h2;
endpackage

// file: core/dot_trace.sv
// Data and ownership trace message generator with AHB-Lite registers
//
// Functional notes
// [RULE_01] see sync pending: read emits full-address sync
// [RULE_02] see reset, wake, debug exit, enable mark sync
// [RULE_03] see event-in pin forces sync when selected
// [RULE_04] see overrun: error code 8 before sync
// [RULE_05] see 255 non-sync messages force sync
// [RULE_06] see sync message carries data, full address
// [RULE_07] see size field and type code 14
// [RULE_08] see two-bit read/write selector per channel
// [RULE_09] see optional 8-bit space ID match
// [RULE_10] see watchpoint enables, reserved bits zero
// [RULE_11] see inclusive start to end range match
// [RULE_12] see start above end never matches
// [RULE_13] see start/end registers, read-write, reset zero
// [RULE_14] see process ID write queues ownership message
// [RULE_15] see counter-forced sync adds ownership message
// [RULE_16] see ownership at least every 256 messages; code adds one only at a counter-forced sync, other syncs clear the count
// [RULE_17] see ownership retried after queue overrun
// [RULE_18] see queue full, no halt: error message
// [RULE_19] see ownership message: 32-bit ID, code 2
// [RULE_20] see ownership only with mode bit 0
// [RULE_21] see process ID register read-write, reset zero
// [RULE_22] see data trace only with mode bit 1
// [RULE_23] see watchpoint bit emits watchpoint message
// [RULE_24] see one queue, event order kept
`timescale 1ns/1ps
module dot_trace (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic [31:0] acc_addr,
  input wire logic [31:0] acc_data,
  input wire logic [1:0] acc_size,
  input wire logic [7:0] acc_space_id,
  input wire logic cpu_pid_wr,
  input wire logic [31:0] cpu_pid_data,
  input wire logic power_wake,
  input wire logic debug_exit,
  input wire logic event_in_pin,
  input wire logic evt_action_sync,
  input wire logic cpu_halt_on_full,
  input wire logic wp_trace_on,
  input wire logic wp_trace_off,
  output logic msg_valid,
  input wire logic msg_ready,
  output logic [5:0] msg_type,
  output logic [31:0] msg_data,
  output logic [31:0] msg_addr,
  output logic [1:0] msg_size,
  output logic [4:0] msg_err
);
  import dot_pkg::*;

  // ==========================================================
  // Pin synchronisers
  logic evt_s1_ff, evt_s2_ff, evt_s3_ff;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      evt_s1_ff <= 1'b0;
      evt_s2_ff <= 1'b0;
      evt_s3_ff <= 1'b0;
    end else begin
      evt_s1_ff <= event_in_pin;
      evt_s2_ff <= evt_s1_ff;
      evt_s3_ff <= evt_s2_ff;
    end
  end
  wire logic evt_rise = evt_s2_ff & ~evt_s3_ff;

  // ==========================================================
  // AHB-Lite register slave, zero wait states
  logic [31:0] ctrl_ff, pid_ff, rd_ff, st_ff [2], en_ff [2];
  logic [1:0] mode_ff;
  logic wr_ph_ff;
  logic [31:0] wa_ff;
  logic own_pend_ff, ovr_data_ff, ovr_own_ff;
  wire logic addr_ph = hsel & hready & htrans[1];
  wire logic bus_wr = wr_ph_ff;
  wire logic pid_bus_wr = bus_wr && wa_ff == OFS_PROCESS_ID;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      wr_ph_ff <= 1'b0;
      wa_ff <= 32'h0000_0000;
    end else begin
      wr_ph_ff <= addr_ph & hwrite;
      wa_ff <= {haddr[31:2], 2'b00};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rd_ff <= 32'h0000_0000;
    end else if (addr_ph && !hwrite) begin
      case ({haddr[31:2], 2'b00})
        OFS_CHAN_CTRL: rd_ff <= ctrl_ff & CTRL_WMASK; // see [RULE_10]
        OFS_START_0: rd_ff <= st_ff[0]; // see [RULE_13]
        OFS_END_0: rd_ff <= en_ff[0];
        OFS_START_1: rd_ff <= st_ff[1];
        OFS_END_1: rd_ff <= en_ff[1];
        OFS_PROCESS_ID: rd_ff <= pid_ff; // see [RULE_21]
        OFS_MODE: rd_ff <= {30'h0, mode_ff};
        OFS_STATUS: rd_ff <= {29'h0, own_pend_ff, ovr_own_ff, ovr_data_ff};
        default: rd_ff <= 32'h0000_0000;
      endcase
    end
  end
  assign hrdata = rd_ff;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ctrl_ff <= CTRL_RESET;
      st_ff[0] <= 32'h0000_0000;
      st_ff[1] <= 32'h0000_0000;
      en_ff[0] <= 32'h0000_0000;
      en_ff[1] <= 32'h0000_0000;
    end else if (bus_wr) begin
      case (wa_ff)
        OFS_CHAN_CTRL: ctrl_ff <= hwdata & CTRL_WMASK; // see [RULE_08]
        OFS_START_0: st_ff[0] <= hwdata; // see [RULE_13]
        OFS_END_0: en_ff[0] <= hwdata;
        OFS_START_1: st_ff[1] <= hwdata;
        OFS_END_1: en_ff[1] <= hwdata;
        default: ;
      endcase
    end
  end

  // CPU writes win over a same-cycle tool write
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pid_ff <= 32'h0000_0000; // see [RULE_21]
    end else if (cpu_pid_wr) begin
      pid_ff <= cpu_pid_data;
    end else if (pid_bus_wr) begin
      pid_ff <= hwdata;
    end
  end

  // Mode bit 1 is also driven by watchpoint trace triggers
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      mode_ff <= 2'b00;
    end else if (bus_wr && wa_ff == OFS_MODE) begin
      mode_ff <= hwdata[1:0];
    end else if (wp_trace_on) begin
      mode_ff[1] <= 1'b1; // see [RULE_22]
    end else if (wp_trace_off) begin
      mode_ff[1] <= 1'b0;
    end
  end

  // ==========================================================
  // Channel match
  logic [1:0] ch_hit, ch_wp;
  for (genvar c = 0; c < 2; c++) begin : g_chan
    localparam int SH = c ? SEL1_HI : SEL0_HI;
    localparam int SL = c ? SID1_LO : SID0_LO;
    localparam int SE = c ? SID1_EN : SID0_EN;
    localparam int WB = c ? WP1_BIT : WP0_BIT;
    logic in_rng, sid_ok;
    assign in_rng = acc_addr >= st_ff[c] && acc_addr <= en_ff[c]; // see [RULE_11] [RULE_12]
    assign sid_ok = !ctrl_ff[SE] || acc_space_id == ctrl_ff[SL+7:SL]; // see [RULE_09]
    assign ch_hit[c] = acc_valid && in_rng && sid_ok &&
      (acc_write ? ctrl_ff[SH] : ctrl_ff[SH-1]); // see [RULE_08]
    assign ch_wp[c] = acc_valid && in_rng && sid_ok && ctrl_ff[WB]; // see [RULE_23]
  end
  wire logic data_ev = |ch_hit & mode_ff[1]; // see [RULE_22]
  wire logic wp_ev = |ch_wp;

  // ==========================================================
  // Sync and periodic counter
  logic sync_pend_ff, mode1_d_ff;
  logic [7:0] period_ff;
  wire logic cnt_force = period_ff == PERIOD_LIMIT; // see [RULE_05]
  logic out_busy;
  wire logic data_take = data_ev & ~out_busy;
  wire logic use_sync = sync_pend_ff | cnt_force;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      mode1_d_ff <= 1'b0;
    end else begin
      mode1_d_ff <= mode_ff[1];
    end
  end

  // New causes win over the clear by a sync message
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      sync_pend_ff <= 1'b1; // see [RULE_02]
    end else if (power_wake || debug_exit || (mode_ff[1] && !mode1_d_ff) ||
                 (evt_rise && evt_action_sync)) begin
      sync_pend_ff <= 1'b1; // see [RULE_02] [RULE_03]
    end else if (data_take) begin
      sync_pend_ff <= 1'b0; // see [RULE_01]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      period_ff <= 8'h00;
    end else if (data_take) begin
      period_ff <= use_sync ? 8'h00 : period_ff + 8'h01; // see [RULE_05]
    end
  end

  // Overrun of data trace: sync pending via error flag
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ovr_data_ff <= 1'b0;
    end else if (data_ev && out_busy) begin
      ovr_data_ff <= 1'b1;
    end else if (data_take) begin
      ovr_data_ff <= 1'b0;
    end
  end

  // ==========================================================
  // Ownership trace
  wire logic own_req = mode_ff[0] & (cpu_pid_wr | pid_bus_wr); // see [RULE_14] [RULE_20]
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      own_pend_ff <= 1'b0;
      ovr_own_ff <= 1'b0;
    end else begin
      if (own_req || (data_take && cnt_force && mode_ff[0])) begin
        own_pend_ff <= 1'b1; // see [RULE_15] [RULE_16]
      end else if (own_sent) begin
        own_pend_ff <= 1'b0;
      end
      if (own_req && out_busy && !cpu_halt_on_full) begin
        ovr_own_ff <= 1'b1; // see [RULE_18]
      end else if (own_sent) begin
        ovr_own_ff <= 1'b0; // see [RULE_17]
      end
    end
  end
  logic own_sent;

  // ==========================================================
  // Output sequencer: one queue, fixed order per event
  typedef enum {ST_IDLE, ST_ERR, ST_DATA, ST_WP, ST_OWN} dot_state_t;
  dot_state_t state_ff;
  logic [31:0] l_addr_ff, l_data_ff;
  logic [1:0] l_size_ff;
  logic l_sync_ff, l_wr_ff, l_err_ff, l_dat_ff, l_wp_ff;
  assign out_busy = state_ff != ST_IDLE;
  assign own_sent = state_ff == ST_OWN && msg_valid && msg_ready;
  wire logic done = msg_valid & msg_ready;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      l_addr_ff <= 32'h0000_0000;
      l_data_ff <= 32'h0000_0000;
      l_size_ff <= SZ_BYTE;
      l_sync_ff <= 1'b0;
      l_wr_ff <= 1'b0;
      l_err_ff <= 1'b0;
      l_dat_ff <= 1'b0;
      l_wp_ff <= 1'b0;
    end else if (!out_busy && (data_ev || wp_ev)) begin
      l_addr_ff <= acc_addr;
      l_data_ff <= acc_data;
      l_size_ff <= acc_size;
      l_sync_ff <= use_sync | ovr_data_ff;
      l_wr_ff <= acc_write;
      l_err_ff <= ovr_data_ff & data_ev; // see [RULE_04]
      l_dat_ff <= data_ev;
      l_wp_ff <= wp_ev;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_ff <= ST_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (data_ev && ovr_data_ff) state_ff <= ST_ERR; // see [RULE_04]
          else if (data_ev) state_ff <= ST_DATA;
          else if (wp_ev) state_ff <= ST_WP;
          else if (own_pend_ff) state_ff <= ST_OWN; // see [RULE_24]
        end
        ST_ERR: if (done) state_ff <= ST_DATA;
        ST_DATA: if (done) state_ff <= l_wp_ff ? ST_WP :
                                   own_pend_ff ? ST_OWN : ST_IDLE;
        ST_WP: if (done) state_ff <= own_pend_ff ? ST_OWN : ST_IDLE;
        ST_OWN: if (done) state_ff <= ST_IDLE;
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      msg_valid <= 1'b0;
      msg_type <= 6'h00;
      msg_data <= 32'h0000_0000;
      msg_addr <= 32'h0000_0000;
      msg_size <= SZ_BYTE;
      msg_err <= 5'h00;
    end else if (!msg_valid || msg_ready) begin
      msg_valid <= 1'b0;
      if (!done) begin
        case (state_ff)
          ST_ERR: begin
            msg_valid <= 1'b1;
            msg_type <= TC_ERROR; // see [RULE_04]
            msg_err <= ERR_DATA_OVR;
          end
          ST_DATA: begin
            msg_valid <= 1'b1; // see [RULE_06] [RULE_07]
            msg_type <= l_wr_ff ? (l_sync_ff ? TC_WRITE_SYNC : TC_WRITE_REL)
                                : (l_sync_ff ? TC_READ_SYNC : TC_READ_REL);
            msg_addr <= l_addr_ff;
            msg_size <= l_size_ff;
            msg_data <= l_size_ff == SZ_BYTE ? {24'h0, l_data_ff[7:0]} :
                        l_size_ff == SZ_HALF ? {16'h0, l_data_ff[15:0]} :
                        l_data_ff;
          end
          ST_WP: begin
            msg_valid <= 1'b1; // see [RULE_23]
            msg_type <= TC_WATCHPOINT;
            msg_addr <= l_addr_ff;
          end
          ST_OWN: begin
            msg_valid <= 1'b1;
            msg_type <= ovr_own_ff ? TC_ERROR : TC_OWNERSHIP; // see [RULE_19]
            msg_err <= ovr_own_ff ? ERR_OWN_OVR : 5'h00;
            msg_data <= pid_ff;
          end
          default: ;
        endcase
      end
    end
  end

  // ==========================================================
  // Checks
  chk_sync_type: assert property (@(posedge sys_clk) disable iff (!reset_n)
    msg_valid && state_ff == ST_DATA && !l_wr_ff && l_sync_ff |->
    msg_type == TC_READ_SYNC) else $error("read sync type wrong"); // see [RULE_07]
  chk_err_first: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state_ff == ST_ERR && done |=> state_ff == ST_DATA)
    else $error("error not followed by data"); // see [RULE_04]
  chk_period_cap: assert property (@(posedge sys_clk) disable iff (!reset_n)
    data_take && period_ff == PERIOD_LIMIT |=> period_ff == 8'h00)
    else $error("period counter not reset"); // see [RULE_05]
  chk_reset_sync: assert property (@(posedge sys_clk)
    !reset_n |=> sync_pend_ff) else $error("sync not pending"); // see [RULE_02]
  chk_empty_range: assert property (@(posedge sys_clk) disable iff (!reset_n)
    st_ff[0] > en_ff[0] |-> !ch_hit[0] && !ch_wp[0])
    else $error("inverted range matched"); // see [RULE_12]
  chk_own_queue: assert property (@(posedge sys_clk) disable iff (!reset_n)
    own_req |=> own_pend_ff) else $error("ownership not queued"); // see [RULE_14]
  chk_own_gate: assert property (@(posedge sys_clk) disable iff (!reset_n)
    msg_valid && msg_type == TC_OWNERSHIP |-> mode_ff[0] || $past(mode_ff[0]))
    else $error("ownership while disabled"); // see [RULE_20]
  chk_own_id: assert property (@(posedge sys_clk) disable iff (!reset_n)
    msg_valid && msg_type == TC_OWNERSHIP |-> msg_data == pid_ff)
    else $error("ownership id mismatch"); // see [RULE_19]
endmodule // dot_trace

// file: verification/dot_tool_model.sv
// Debug tool model: takes trace messages, stalling when asked
`timescale 1ns/1ps
module dot_tool_model (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic slow,
  input wire logic msg_valid,
  output logic msg_ready,
  input wire logic [5:0] msg_type,
  input wire logic [31:0] msg_data,
  input wire logic [31:0] msg_addr,
  input wire logic [1:0] msg_size,
  input wire logic [4:0] msg_err,
  output logic got,
  output logic [5:0] got_type,
  output logic [31:0] got_data,
  output logic [31:0] got_addr,
  output logic [1:0] got_size,
  output logic [4:0] got_err
);
  logic [1:0] gap_ff;
  // =====================================================
  // Ready: three stalled cycles in four backs up the sender
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      gap_ff <= 2'h0;
      msg_ready <= 1'b0;
    end else begin
      gap_ff <= gap_ff + 2'h1;
      msg_ready <= !slow || (gap_ff == 2'h3);
    end
  end
  // =====================================================
  // Capture one message per accepted handshake
  always_ff @(posedge sys_clk) begin
    got <= reset_n && msg_valid && msg_ready;
    if (msg_valid && msg_ready) begin
      got_type <= msg_type;
      got_data <= msg_data;
      got_addr <= msg_addr;
      got_size <= msg_size;
      got_err <= msg_err;
    end
  end
endmodule // dot_tool_model

// file: verification/dot_trace_tb_top.sv
// Testbench for the data and ownership trace block
`timescale 1ns/1ps
module dot_trace_tb_top;
  import dot_pkg::*;
  logic sys_clk, reset_n, hsel, hwrite, hready, slow, got;
  logic [31:0] haddr, hwdata, hrdata, rd_v;
  logic [1:0] htrans, acc_size, msg_size, got_size;
  logic [2:0] hsize;
  logic hresp, acc_valid, acc_write, cpu_pid_wr, power_wake, debug_exit;
  logic event_in_pin, evt_action_sync, cpu_halt_on_full;
  logic wp_trace_on, wp_trace_off, msg_valid, msg_ready;
  logic [31:0] acc_addr, acc_data, cpu_pid_data, msg_data, msg_addr;
  logic [31:0] got_data, got_addr;
  logic [7:0] acc_space_id;
  logic [5:0] msg_type, got_type;
  logic [4:0] msg_err, got_err;
  logic [31:0] ofs [7];
  int n_fail, check_count, cyc;
  dot_trace dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .acc_valid(acc_valid),
    .acc_write(acc_write), .acc_addr(acc_addr), .acc_data(acc_data),
    .acc_size(acc_size), .acc_space_id(acc_space_id),
    .cpu_pid_wr(cpu_pid_wr), .cpu_pid_data(cpu_pid_data),
    .power_wake(power_wake), .debug_exit(debug_exit),
    .event_in_pin(event_in_pin), .evt_action_sync(evt_action_sync),
    .cpu_halt_on_full(cpu_halt_on_full), .wp_trace_on(wp_trace_on),
    .wp_trace_off(wp_trace_off), .msg_valid(msg_valid),
    .msg_ready(msg_ready), .msg_type(msg_type), .msg_data(msg_data),
    .msg_addr(msg_addr), .msg_size(msg_size), .msg_err(msg_err));
  dot_tool_model tool_u (.sys_clk(sys_clk), .reset_n(reset_n),
    .slow(slow), .msg_valid(msg_valid), .msg_ready(msg_ready),
    .msg_type(msg_type), .msg_data(msg_data), .msg_addr(msg_addr),
    .msg_size(msg_size), .msg_err(msg_err), .got(got),
    .got_type(got_type), .got_data(got_data), .got_addr(got_addr),
    .got_size(got_size), .got_err(got_err));
  // =====================================================
  // Clock and hang guard
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  // =====================================================
  // Tasks
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check_val(input string what, input logic [31:0] exp,
                           input logic [31:0] seen);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= HT_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hready !== 1'b1);
    rd_v = hrdata;
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check_val($sformatf("reg %h", a), exp, rd_v);
  endtask
  task automatic access(input logic w, input logic [31:0] a,
    input logic [31:0] d, input logic [1:0] s, input logic [7:0] sid,
    input int n);
    @(posedge sys_clk);
    acc_valid <= 1'b1;
    acc_write <= w;
    acc_addr <= a;
    acc_data <= d;
    acc_size <= s;
    acc_space_id <= sid;
    repeat (n) @(posedge sys_clk);
    acc_valid <= 1'b0;
  endtask
  task automatic pulse(input int k);
    @(posedge sys_clk);
    case (k)
      0: debug_exit <= 1'b1;
      1: power_wake <= 1'b1;
      2: wp_trace_on <= 1'b1;
      3: cpu_pid_wr <= 1'b1;
      default: event_in_pin <= 1'b1;
    endcase
    @(posedge sys_clk);
    {debug_exit, power_wake, wp_trace_on, cpu_pid_wr, event_in_pin} <= 5'h0;
  endtask
  // Field select: bit 0 data, bit 1 address and size
  task automatic expect_msg(input logic [5:0] t, input logic [31:0] d,
    input logic [31:0] a, input logic [1:0] s, input logic [1:0] chk);
    int w;
    w = 0;
    do begin
      @(posedge sys_clk);
      #1;
      w++;
    end while (got !== 1'b1 && w < 60);
    check_val("msg arrived", 32'h1, {31'h0, got});
    check_val("msg type", {26'h0, t}, {26'h0, got_type});
    if (chk[0]) check_val("msg data", d, got_data);
    if (chk[1]) check_val("msg addr", a, got_addr);
    if (chk[1]) check_val("msg size", {30'h0, s}, {30'h0, got_size});
    if (t == TC_ERROR) check_val("msg err", d, {27'h0, got_err});
  endtask
  task automatic quiet();
    int c;
    c = 0;
    repeat (12) begin
      @(posedge sys_clk);
      #1;
      if (got === 1'b1) c++;
    end
    check_val("extra msgs", 32'h0, c);
  endtask
  // =====================================================
  // Main sequence
  initial begin
    ofs = '{OFS_CHAN_CTRL, OFS_START_0, OFS_END_0, OFS_START_1, OFS_END_1,
            OFS_PROCESS_ID, OFS_MODE};
    {reset_n, hsel, hwrite, acc_valid, acc_write, cpu_pid_wr} = 6'h0;
    {power_wake, debug_exit, event_in_pin, evt_action_sync} = 4'h0;
    {cpu_halt_on_full, wp_trace_on, wp_trace_off, slow} = 4'h0;
    {haddr, hwdata, acc_addr, acc_data, cpu_pid_data} = 160'h0;
    {htrans, acc_size, acc_space_id} = 12'h0;
    hsize = 3'h2;
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    foreach (ofs[i]) rd_chk(ofs[i], 32'h0);
    bus(1'b1, OFS_CHAN_CTRL, 32'hFFFF_FFFF);
    rd_chk(OFS_CHAN_CTRL, 32'hF00F_FFFF);
    for (int i = 1; i < 6; i++) bus(1'b1, ofs[i], 32'h1234_5670 + i);
    for (int i = 1; i < 6; i++) rd_chk(ofs[i], 32'h1234_5670 + i);
    bus(1'b1, 32'h0000_0040, 32'hFFFF_FFFF);
    rd_chk(32'h0000_0040, 32'h0);
    $display("test registers finished");
    bus(1'b1, OFS_CHAN_CTRL, 32'h4000_0000);
    bus(1'b1, OFS_START_0, 32'h0000_0100);
    bus(1'b1, OFS_END_0, 32'h0000_0100);
    pulse(2);
    rd_chk(OFS_MODE, 32'h2);
    access(1'b0, 32'h100, 32'hAB, SZ_BYTE, 8'h0, 1);
    expect_msg(6'd14, 32'hAB, 32'h100, 2'b00, 2'h3);
    access(1'b0, 32'h100, 32'h1234_5678, SZ_WORD, 8'h0, 1);
    expect_msg(6'd6, 32'h1234_5678, 32'h0, 2'h0, 2'h1);
    access(1'b0, 32'h104, 32'h1, SZ_WORD, 8'h0, 1);
    access(1'b1, 32'h100, 32'h1, SZ_WORD, 8'h0, 1);
    quiet();
    pulse(0);
    access(1'b0, 32'h100, 32'h55AA, SZ_HALF, 8'h0, 1);
    expect_msg(6'd14, 32'h55AA, 32'h100, 2'b01, 2'h3);
    pulse(1);
    access(1'b0, 32'h100, 32'h7, SZ_WORD, 8'h0, 1);
    expect_msg(6'd14, 32'h7, 32'h100, 2'b10, 2'h3);
    $display("test data sync finished");
    bus(1'b1, OFS_CHAN_CTRL, 32'h1005_A800);
    bus(1'b1, OFS_START_1, 32'h0000_0200);
    bus(1'b1, OFS_END_1, 32'h0000_01FF);
    access(1'b0, 32'h200, 32'h9, SZ_WORD, 8'h5A, 1);
    quiet();
    bus(1'b1, OFS_END_1, 32'h0000_0200);
    access(1'b0, 32'h200, 32'h9, SZ_WORD, 8'h11, 1);
    quiet();
    bus(1'b1, OFS_CHAN_CTRL, 32'h1005_A802);
    access(1'b0, 32'h200, 32'h9, SZ_WORD, 8'h5A, 1);
    expect_msg(6'd6, 32'h9, 32'h0, 2'h0, 2'h1);
    expect_msg(TC_WATCHPOINT, 32'h0, 32'h0, 2'h0, 2'h0);
    bus(1'b1, OFS_CHAN_CTRL, 32'h1005_A800);
    $display("test channels finished");
    evt_action_sync <= 1'b1;
    pulse(4);
    repeat (4) @(posedge sys_clk);
    access(1'b0, 32'h200, 32'h3C, SZ_WORD, 8'h5A, 1);
    expect_msg(6'd14, 32'h3C, 32'h200, 2'b10, 2'h3);
    slow <= 1'b1;
    access(1'b0, 32'h200, 32'h4, SZ_WORD, 8'h5A, 2);
    expect_msg(6'd6, 32'h4, 32'h0, 2'h0, 2'h1);
    access(1'b0, 32'h200, 32'h5, SZ_WORD, 8'h5A, 1);
    expect_msg(6'd8, 32'h2, 32'h0, 2'h0, 2'h0);
    expect_msg(6'd14, 32'h5, 32'h200, 2'b10, 2'h3);
    slow <= 1'b0;
    $display("test event and overrun finished");
    bus(1'b1, OFS_MODE, 32'h1);
    cpu_pid_data <= 32'hCAFE_0001;
    pulse(3);
    expect_msg(6'd2, 32'hCAFE_0001, 32'h0, 2'h0, 2'h1);
    rd_chk(OFS_PROCESS_ID, 32'hCAFE_0001);
    bus(1'b1, OFS_MODE, 32'h0);
    pulse(3);
    quiet();
    $display("test ownership finished");
    bus(1'b1, OFS_MODE, 32'h3);
    pulse(0);
    access(1'b0, 32'h200, 32'h1, SZ_WORD, 8'h5A, 1);
    expect_msg(6'd14, 32'h1, 32'h200, 2'b10, 2'h3);
    for (int i = 0; i < 255; i++) begin
      access(1'b0, 32'h200, i, SZ_WORD, 8'h5A, 1);
      expect_msg(6'd6, i, 32'h0, 2'h0, 2'h1);
    end
    access(1'b0, 32'h200, 32'hF00D, SZ_WORD, 8'h5A, 1);
    expect_msg(6'd14, 32'hF00D, 32'h200, 2'b10, 2'h3);
    expect_msg(6'd2, 32'hCAFE_0001, 32'h0, 2'h0, 2'h1);
    $display("test periodic finished");
    end_of_test();
  end
endmodule // dot_trace_tb_top
